/* design/prpm_top.sv */
// Priority remap, port mirroring and port VLAN membership
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/100ps
`include "prpm_cfg.svh"

// Summary of operation
// RQ1: With regeneration on, egress priority comes from an 8-entry table.
// RQ2: Level 7 is highest, 0 lowest; queue class is level over two.
// RQ3: Frames without priority use level 0 for lookup and queueing.
// RQ4: Mirror copies go to one programmable target port.
// RQ5: Each source port mirrors none, receive, transmit or both directions.
// RQ6: Mirroring never stalls or alters normal forwarding; only copies made.
// RQ7: Copies the slower target cannot take are discarded.
// RQ8: Software mirrors three ports at most, target at least as fast.
// RQ9: Default VLAN holds all ports after reset and cannot be deleted.
// RQ10: Sharing flag resets off; when off, no VLAN learning or advertising.
// RQ11: Adding a port already in another VLAN is refused.
// RQ12: Each VLAN keeps a port bitmap; forwarding limited to members.
// RQ13: VLAN name holds 32 characters, read-only once VLAN created.
// RQ14: IP interface accepted only on existing VLAN, one per VLAN.
// RQ15: Per-port settings kept for ports 1 to 26.
// RQ16: Copies queue in arrival order; new copies dropped when queue full.
module prpm_top
    import prpm_pkg::*;
#(
    parameter int NP = `PRPM_NPORT,
    parameter int NV = `PRPM_NVLAN,
    parameter int QD = `PRPM_MIRQ_DEPTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Egress priority
    input wire logic eg_valid_i,
    input wire logic eg_tagged_i,
    input wire logic [2:0] eg_pri_i,
    output logic eg_valid_o,
    output logic [2:0] eg_pri_o,
    output logic [1:0] eg_queue_o,
    // Forwarding filter
    input wire logic fwd_valid_i,
    input wire logic [4:0] fwd_src_i,
    input wire logic [NP-1:0] fwd_mask_i,
    output logic fwd_valid_o,
    output logic [NP-1:0] fwd_mask_o,
    // Packet events, bit 0 is port 1
    input wire logic [NP-1:0] rx_pkt_i,
    input wire logic [NP-1:0] tx_pkt_i,
    // Mirror copy stream
    output logic mir_valid_o,
    input wire logic mir_ready_i,
    output logic [4:0] mir_src_o,
    output logic mir_dir_tx_o,
    output logic [4:0] mir_port_o,
    // VLAN sharing enable
    output logic gvrp_en_o
);
    logic ack_q;
    logic acc;
    logic wr;
    logic regen_q;
    logic gvrp_q;
    logic [23:0] remap_q;
    logic [4:0] tgt_q;
    logic [2*NP-1:0] mode_q;
    logic [15:0] drop_q;
    logic [1:0] vsel_q;
    logic [4:0] nidx_q;
    logic refused_q;
    logic [NV-1:0] exist_q;
    logic [NP-1:0] memb_q [NV];
    logic [7:0] name_q [NV][`PRPM_NAME_LEN];
    logic [31:0] ip_q [NV];
    logic [NV-1:0] ipv_q;
    logic [31:0] rd_d;
    logic [NP-1:0] want;
    logic [NP-1:0] in_fwd;
    logic [NP-1:0] fwd_d;
    logic [4:0] port_idx;
    logic conflict;
    logic pick;
    logic [5:0] pick_d;
    logic q_ready;
    logic [5:0] q_data;
    prpm_pri_t rm_pri;
    logic [1:0] rm_queue;

    // Full-word bus write (all four byte selects) commits once, on the edge that raises ack
    assign acc = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr = acc && wb_we_i && (wb_sel_i == 4'hf);
    assign wb_ack_o = ack_q;
    assign port_idx = wb_dat_i[4:0] - 5'h01;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            ack_q <= acc;
            wb_dat_o <= acc ? rd_d : 32'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            regen_q <= 1'b0;
            gvrp_q <= 1'b0; // [RQ10]
            remap_q <= `PRPM_REMAP_RST;
            tgt_q <= `PRPM_MIR_TGT_RST;
            mode_q <= '0;
            vsel_q <= `PRPM_DEF_VLAN;
            nidx_q <= 5'h00;
        end else if (wr) begin
            unique case (wb_adr_i)
                `PRPM_OFS_CTRL: begin
                    regen_q <= wb_dat_i[`PRPM_CTRL_REGEN];
                    gvrp_q <= wb_dat_i[`PRPM_CTRL_GVRP];
                end
                `PRPM_OFS_REMAP: remap_q <= wb_dat_i[23:0]; // [RQ1]
                `PRPM_OFS_MIR_TGT: begin
                    // Only ports 1..26 may be a target [RQ15]
                    if (wb_dat_i[4:0] != 5'h00 && port_idx < 5'(NP)) begin
                        tgt_q <= wb_dat_i[4:0]; // [RQ4]
                    end
                end
                `PRPM_OFS_MIR_LO: mode_q[31:0] <= wb_dat_i; // [RQ5]
                `PRPM_OFS_MIR_HI: begin
                    mode_q[2*NP-1:32] <= wb_dat_i[2*NP-33:0];
                end
                `PRPM_OFS_VSEL: vsel_q <= wb_dat_i[1:0];
                `PRPM_OFS_VNIDX: nidx_q <= wb_dat_i[4:0];
                default: begin
                end
            endcase
        end
    end

    // Port held by any VLAN other than the selected one
    always_comb begin
        conflict = 1'b0;
        for (int v = 0; v < NV; v++) begin
            if (v != int'(vsel_q) && exist_q[v] && memb_q[v][port_idx]) begin
                conflict = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            exist_q <= NV'(1); // [RQ9]
            ipv_q <= '0;
            refused_q <= 1'b0;
            for (int v = 0; v < NV; v++) begin
                memb_q[v] <= (v == 0) ? '1 : '0; // [RQ9]
                ip_q[v] <= 32'h0;
            end
        end else if (wr) begin
            unique case (wb_adr_i)
                `PRPM_OFS_VCMD: begin
                    refused_q <= 1'b0;
                    if (wb_dat_i[`PRPM_VCMD_CREATE]) begin
                        refused_q <= exist_q[vsel_q];
                        exist_q[vsel_q] <= 1'b1;
                    end else if (wb_dat_i[`PRPM_VCMD_DELETE]) begin
                        // Default VLAN stays [RQ9]
                        if (vsel_q == `PRPM_DEF_VLAN) begin
                            refused_q <= 1'b1;
                        end else begin
                            exist_q[vsel_q] <= 1'b0;
                            memb_q[vsel_q] <= '0;
                            ipv_q[vsel_q] <= 1'b0;
                        end
                    end else if (wb_dat_i[`PRPM_VCMD_IPCLR]) begin
                        ipv_q[vsel_q] <= 1'b0;
                    end
                end
                `PRPM_OFS_VADD: begin
                    if (!exist_q[vsel_q] || conflict ||
                        port_idx >= 5'(NP)) begin
                        refused_q <= 1'b1; // [RQ11] [RQ15]
                    end else begin
                        refused_q <= 1'b0;
                        memb_q[vsel_q][port_idx] <= 1'b1; // [RQ12]
                    end
                end
                `PRPM_OFS_VREM: begin
                    refused_q <= port_idx >= 5'(NP);
                    if (port_idx < 5'(NP)) begin
                        memb_q[vsel_q][port_idx] <= 1'b0;
                    end
                end
                `PRPM_OFS_VIP: begin
                    // One interface per existing VLAN [RQ14]
                    if (!exist_q[vsel_q] || ipv_q[vsel_q]) begin
                        refused_q <= 1'b1;
                    end else begin
                        refused_q <= 1'b0;
                        ip_q[vsel_q] <= wb_dat_i;
                        ipv_q[vsel_q] <= 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Name is writable only before creation [RQ13]
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int v = 0; v < NV; v++) begin
                for (int c = 0; c < `PRPM_NAME_LEN; c++) begin
                    name_q[v][c] <= 8'h00;
                end
            end
        end else if (wr && wb_adr_i == `PRPM_OFS_VNAME &&
                     !exist_q[vsel_q]) begin
            name_q[vsel_q][nidx_q] <= wb_dat_i[7:0]; // [RQ13]
        end
    end

    always_comb begin
        rd_d = 32'h0;
        unique case (wb_adr_i)
            `PRPM_OFS_CTRL: begin
                rd_d[`PRPM_CTRL_REGEN] = regen_q;
                rd_d[`PRPM_CTRL_GVRP] = gvrp_q;
            end
            `PRPM_OFS_REMAP: rd_d[23:0] = remap_q;
            `PRPM_OFS_MIR_TGT: rd_d[4:0] = tgt_q;
            `PRPM_OFS_MIR_LO: rd_d = mode_q[31:0];
            `PRPM_OFS_MIR_HI: rd_d[2*NP-33:0] = mode_q[2*NP-1:32];
            `PRPM_OFS_MIR_DROP: rd_d[15:0] = drop_q;
            `PRPM_OFS_VSEL: rd_d[1:0] = vsel_q;
            `PRPM_OFS_VCMD: begin
                rd_d[0] = exist_q[vsel_q];
                rd_d[`PRPM_VCMD_IPV] = ipv_q[vsel_q];
                rd_d[`PRPM_VCMD_REFUSED] = refused_q;
            end
            `PRPM_OFS_VMEMB: rd_d[NP-1:0] = memb_q[vsel_q];
            `PRPM_OFS_VNAME: rd_d[7:0] = name_q[vsel_q][nidx_q];
            `PRPM_OFS_VNIDX: rd_d[4:0] = nidx_q;
            `PRPM_OFS_VIP: rd_d = ip_q[vsel_q];
            default: rd_d = 32'h0;
        endcase
    end

    // Flag gates all learning and advertising outside [RQ10]
    assign gvrp_en_o = gvrp_q;

    prpm_remap u_remap (
        .table_i(remap_q),
        .regen_i(regen_q),
        .tagged_i(eg_tagged_i),
        .pri_i(eg_pri_i),
        .pri_o(rm_pri),
        .queue_o(rm_queue)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eg_valid_o <= 1'b0;
            eg_pri_o <= 3'h0;
            eg_queue_o <= 2'h0;
        end else begin
            eg_valid_o <= eg_valid_i;
            eg_pri_o <= rm_pri; // [RQ1] [RQ3]
            eg_queue_o <= rm_queue; // [RQ2]
        end
    end

    // Forwarding sees members of every VLAN that holds the source
    always_comb begin
        in_fwd = '0;
        for (int v = 0; v < NV; v++) begin
            if (exist_q[v] && memb_q[v][fwd_src_i - 5'h01]) begin
                in_fwd = in_fwd | memb_q[v];
            end
        end
        fwd_d = fwd_mask_i & in_fwd; // [RQ12]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fwd_valid_o <= 1'b0;
            fwd_mask_o <= '0;
        end else begin
            // Never waits on the mirror path [RQ6]
            fwd_valid_o <= fwd_valid_i;
            fwd_mask_o <= fwd_d;
        end
    end

    // Per-port mirror wish, the target never mirrors itself
    for (genvar p = 0; p < NP; p++) begin : g_mir
        assign want[p] = (tgt_q != 5'(p + 1)) &&
            ((rx_pkt_i[p] && mode_q[2*p]) ||
             (tx_pkt_i[p] && mode_q[2*p+1])); // [RQ5]
    end

    // Lowest port wins a shared cycle; receive before transmit
    always_comb begin
        pick = 1'b0;
        pick_d = 6'h00;
        for (int p = NP - 1; p >= 0; p--) begin
            if (want[p]) begin
                pick = 1'b1;
                pick_d = {5'(p + 1), !(rx_pkt_i[p] && mode_q[2*p])};
            end
        end
    end

    // Other copies in the same cycle are lost; counted once per cycle when two or more ports want one or the queue is full
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drop_q <= 16'h0000;
        end else if (wr && wb_adr_i == `PRPM_OFS_MIR_DROP) begin
            drop_q <= 16'h0000;
        end else if (pick && (!q_ready || $countones(want) > 1)) begin
            drop_q <= drop_q + 16'h0001; // [RQ7] [RQ16]
        end
    end

    prpm_mirq #(
        .W(6),
        .D(QD)
    ) u_mirq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(pick),
        .in_ready_o(q_ready),
        .in_data_i(pick_d),
        .out_valid_o(mir_valid_o),
        .out_ready_i(mir_ready_i),
        .out_data_o(q_data)
    );

    assign mir_src_o = q_data[5:1];
    assign mir_dir_tx_o = q_data[0];
    assign mir_port_o = tgt_q; // [RQ4]

    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_timing: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    a_regen_lookup: assert property (@(posedge clk_i) // [RQ1]
        disable iff (rst_i) eg_valid_i && regen_q && !eg_tagged_i |=>
        eg_pri_o == $past(remap_q[2:0])) else $error("bad regenerated level");
    a_regen_bypass: assert property (@(posedge clk_i) // [RQ3]
        disable iff (rst_i) eg_valid_i && !regen_q && !eg_tagged_i |=>
        eg_pri_o == 3'h0) else $error("untagged frame not level 0");
    a_queue_class: assert property (@(posedge clk_i) // [RQ2]
        disable iff (rst_i) eg_valid_i && eg_tagged_i && !regen_q |=>
        eg_queue_o == $past(eg_pri_i[2:1])) else $error("bad queue class");
    a_default_kept: assert property (@(posedge clk_i) // [RQ9]
        disable iff (rst_i) exist_q[0]) else $error("default VLAN vanished");
    a_gvrp_reset: assert property (@(posedge clk_i) // [RQ10]
        rst_i |=> !gvrp_en_o) else $error("sharing flag not off after reset");
    a_add_refused: assert property (@(posedge clk_i) // [RQ11]
        disable iff (rst_i) wr && wb_adr_i == `PRPM_OFS_VADD && conflict |=>
        refused_q && $stable(memb_q[vsel_q]))
        else $error("conflicting add taken");
    a_fwd_members: assert property (@(posedge clk_i) // [RQ12]
        disable iff (rst_i) fwd_valid_i ##1 fwd_valid_o |->
        (fwd_mask_o & ~$past(in_fwd)) == '0)
        else $error("forward outside VLAN");
    a_mir_drop: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ16]
        pick && !q_ready && !wr |=> drop_q == $past(drop_q) + 16'h0001)
        else $error("full-queue copy not counted");
    a_fwd_free: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
        fwd_valid_i |=> fwd_valid_o) else $error("forwarding delayed");
endmodule

/* inc/prpm_cfg.svh */
// Constants for the priority remap and port mirror block
`ifndef PRPM_CFG_SVH
`define PRPM_CFG_SVH

`define PRPM_NPORT 26
`define PRPM_NVLAN 4
`define PRPM_NAME_LEN 32
`define PRPM_MIRQ_DEPTH 4

`define PRPM_OFS_CTRL 8'h00
`define PRPM_OFS_REMAP 8'h04
`define PRPM_OFS_MIR_TGT 8'h08
`define PRPM_OFS_MIR_LO 8'h0c
`define PRPM_OFS_MIR_HI 8'h10
`define PRPM_OFS_MIR_DROP 8'h14
`define PRPM_OFS_VSEL 8'h18
`define PRPM_OFS_VCMD 8'h1c
`define PRPM_OFS_VADD 8'h20
`define PRPM_OFS_VREM 8'h24
`define PRPM_OFS_VMEMB 8'h28
`define PRPM_OFS_VNAME 8'h2c
`define PRPM_OFS_VNIDX 8'h30
`define PRPM_OFS_VIP 8'h34

`define PRPM_CTRL_REGEN 0
`define PRPM_CTRL_GVRP 1
`define PRPM_VCMD_CREATE 0
`define PRPM_VCMD_DELETE 1
`define PRPM_VCMD_IPCLR 2
`define PRPM_VCMD_REFUSED 2
`define PRPM_VCMD_IPV 1

`define PRPM_REMAP_RST 24'hfac688
`define PRPM_MIR_TGT_RST 5'h01
`define PRPM_DEF_VLAN 2'h0

`endif

/* inc/prpm_pkg.sv */
// Types shared by the priority remap and port mirror block
package prpm_pkg;
    typedef enum logic [1:0] {
        PRPM_MIR_NONE,
        PRPM_MIR_RX,
        PRPM_MIR_TX,
        PRPM_MIR_BOTH
    } prpm_mir_t;
    typedef logic [2:0] prpm_pri_t;
endpackage

/* design/prpm_remap.sv */
// Egress user priority lookup through the eight-entry table
`timescale 1ns/100ps
module prpm_remap
    import prpm_pkg::*;
(
    // Table and mode
    input wire logic [23:0] table_i,
    input wire logic regen_i,
    // Frame priority
    input wire logic tagged_i,
    input wire prpm_pri_t pri_i,
    output prpm_pri_t pri_o,
    output logic [1:0] queue_o
);
    prpm_pri_t level;

    always_comb begin
        // Untagged frames count as level 0 [RQ3]
        level = tagged_i ? pri_i : 3'h0;
        pri_o = regen_i ? table_i[level*3 +: 3] : level; // [RQ1]
        // Pairs of levels share one queue, 7 highest [RQ2]
        queue_o = pri_o[2:1];
    end
endmodule

/* design/prpm_mirq.sv */
// Mirror copy queue toward the analyser port
`timescale 1ns/100ps
module prpm_mirq #(
    parameter int W = 6,
    parameter int D = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_q != (AW+1)'(D));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // Pointers wrap at D, which need not be a power of two
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* tb/prpm_analyser.sv */
// Analyser model standing on the mirror target port
`timescale 1ns/100ps
module prpm_analyser (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Mirror copy stream
    input wire logic mir_valid_i,
    input wire logic [4:0] mir_src_i,
    input wire logic mir_dir_tx_i,
    output logic mir_ready_o,
    // Stall request from the bench
    input wire logic slow_i
);
    logic [5:0] cap[$];
    // Registered ready, so a stall lands one cycle after it is asked
    always @(posedge clk_i) begin
        if (rst_i) begin
            mir_ready_o <= 1'b0;
        end else begin
            mir_ready_o <= !slow_i;
        end
    end
    // Every copy taken at the target port is logged in order
    always @(posedge clk_i) begin
        if (!rst_i && mir_valid_i && mir_ready_o) begin
            cap.push_back({mir_src_i, mir_dir_tx_i});
        end
    end
endmodule

/* tb/test_prpm_top.sv */
// Bench for the priority remap and port mirror block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
    err_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end end
module test_prpm_top;
    import prpm_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rdat;
    logic eg_valid_i, eg_tagged_i, eg_valid_o;
    logic [2:0] eg_pri_i, eg_pri_o;
    logic [1:0] eg_queue_o;
    logic fwd_valid_i, fwd_valid_o, mir_valid_o, mir_ready_i;
    logic [4:0] fwd_src_i, mir_src_o, mir_port_o;
    logic [25:0] fwd_mask_i, fwd_mask_o, rx_pkt_i, tx_pkt_i;
    logic mir_dir_tx_o, gvrp_en_o, slow;
    logic [23:0] tbl;
    logic [5:0] expq[$];
    int err_count = 0;
    int checked = 0;
    int k;
    prpm_top dut (.*);
    prpm_analyser ana (.clk_i(clk_i), .rst_i(rst_i), .mir_valid_i(mir_valid_o),
        .mir_src_i(mir_src_o), .mir_dir_tx_i(mir_dir_tx_o),
        .mir_ready_o(mir_ready_i), .slow_i(slow));
    always #50 clk_i = ~clk_i;
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] a,
            input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 20) begin
            err_count++;
            stop_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hf);
    endtask
    task automatic rd(input string nm, input logic [7:0] a,
            input logic [31:0] e);
        wb(1'b0, a, 32'h0, 4'hf);
        `CHK(nm, e, rdat)
    endtask
    task automatic egr(input logic tg, input logic [2:0] p,
            input logic [2:0] e);
        @(posedge clk_i);
        eg_valid_i <= 1'b1;
        eg_tagged_i <= tg;
        eg_pri_i <= p;
        @(posedge clk_i);
        eg_valid_i <= 1'b0;
        @(posedge clk_i);
        `CHK("eg_valid", 1'b1, eg_valid_o)
        `CHK("eg_pri", e, eg_pri_o)
        `CHK("eg_queue", e[2:1], eg_queue_o)
    endtask
    task automatic fwd(input logic [4:0] s, input logic [25:0] e);
        @(posedge clk_i);
        fwd_valid_i <= 1'b1;
        fwd_src_i <= s;
        fwd_mask_i <= 26'h3ffffff;
        @(posedge clk_i);
        fwd_valid_i <= 1'b0;
        @(posedge clk_i);
        `CHK("fwd_valid", 1'b1, fwd_valid_o)
        `CHK("fwd_mask", e, fwd_mask_o)
    endtask
    task automatic pls(input logic [25:0] rx, input logic [25:0] tx);
        @(posedge clk_i);
        rx_pkt_i <= rx;
        tx_pkt_i <= tx;
        @(posedge clk_i);
        rx_pkt_i <= '0;
        tx_pkt_i <= '0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic wcap(input int n);
        int i;
        for (i = 0; i < 40 && ana.cap.size() != n; i++) @(posedge clk_i);
        `CHK("copies", n, ana.cap.size())
        if (ana.cap.size() != n) stop_test();
    endtask
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, eg_valid_i, eg_tagged_i} = '0;
        {wb_adr_i, wb_sel_i, wb_dat_i, eg_pri_i} = '0;
        {fwd_valid_i, fwd_src_i, fwd_mask_i, rx_pkt_i, tx_pkt_i} = '0;
        slow = 1'b0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("ctrl", 8'h00, 32'h0);
        rd("remap", 8'h04, 32'hfac688);
        rd("target", 8'h08, 32'h1);
        rd("members0", 8'h28, 32'h3ffffff);
        rd("unmapped", 8'h3c, 32'h0);
        `CHK("gvrp", 1'b0, gvrp_en_o)
        $display("test reset done");
        for (k = 0; k < 8; k++) egr(1'b1, k[2:0], k[2:0]);
        egr(1'b0, 3'd5, 3'd0);
        tbl = '0;
        for (k = 0; k < 8; k++) tbl[3*k +: 3] = 3'(7 - k);
        wr(8'h04, {8'h0, tbl});
        wb(1'b1, 8'h00, 32'h3, 4'h3);
        rd("ctrl_part", 8'h00, 32'h0);
        wr(8'h00, 32'h3);
        `CHK("gvrp", 1'b1, gvrp_en_o)
        for (k = 0; k < 8; k++) egr(1'b1, k[2:0], 3'(7 - k));
        egr(1'b0, 3'd4, 3'd7);
        $display("test remap done");
        // Three sources only, target fast enough
        wr(8'h08, 32'd5);
        wr(8'h08, 32'd27);
        rd("target", 8'h08, 32'd5);
        `CHK("mir_port", 5'd5, mir_port_o)
        wr(8'h0c, 32'h390);
        wr(8'h10, 32'hc0000);
        pls(26'h4, 26'h0);
        pls(26'h0, 26'h4);
        pls(26'h0, 26'h8);
        pls(26'h8, 26'h0);
        pls(26'h2000000, 26'h0);
        pls(26'h0, 26'h2000000);
        pls(26'h10, 26'h10);
        pls(26'h1, 26'h1);
        pls(26'h2000004, 26'h0);
        expq = '{6'h06, 6'h09, 6'h34, 6'h35, 6'h06};
        wcap(5);
        rd("drops", 8'h14, 32'h1);
        // Analyser stalls; queue of four fills and overflows
        @(posedge clk_i);
        slow <= 1'b1;
        repeat (3) @(posedge clk_i);
        rx_pkt_i <= 26'h4;
        repeat (6) @(posedge clk_i);
        rx_pkt_i <= '0;
        fwd(5'd1, 26'h3ffffff);
        egr(1'b1, 3'd6, 3'd1);
        `CHK("mir_valid", 1'b1, mir_valid_o)
        rd("drops", 8'h14, 32'h3);
        slow <= 1'b0;
        for (k = 0; k < 4; k++) expq.push_back(6'h06);
        wcap(9);
        for (k = 0; k < 9; k++) `CHK("copy", expq[k], ana.cap[k])
        wr(8'h14, 32'h0);
        rd("drops", 8'h14, 32'h0);
        $display("test mirror done");
        wr(8'h18, 32'd1);
        wr(8'h34, 32'h0a000009);
        rd("vcmd", 8'h1c, 32'h4);
        wr(8'h1c, 32'h1);
        rd("vcmd", 8'h1c, 32'h1);
        wr(8'h20, 32'd7);
        rd("vcmd", 8'h1c, 32'h5);
        wr(8'h20, 32'd27);
        rd("vcmd", 8'h1c, 32'h5);
        wr(8'h18, 32'd0);
        wr(8'h24, 32'd7);
        rd("vcmd", 8'h1c, 32'h1);
        wr(8'h1c, 32'h2);
        rd("vcmd", 8'h1c, 32'h5);
        wr(8'h18, 32'd1);
        wr(8'h20, 32'd7);
        rd("members1", 8'h28, 32'h40);
        fwd(5'd7, 26'h40);
        fwd(5'd1, 26'h3ffffbf);
        wr(8'h34, 32'h0a000001);
        rd("vcmd", 8'h1c, 32'h3);
        wr(8'h34, 32'h0a000002);
        rd("vcmd", 8'h1c, 32'h7);
        rd("ip", 8'h34, 32'h0a000001);
        wr(8'h1c, 32'h4);
        rd("vcmd", 8'h1c, 32'h1);
        wr(8'h18, 32'd3);
        wr(8'h34, 32'h0a000003);
        rd("vcmd", 8'h1c, 32'h4);
        wr(8'h18, 32'd2);
        wr(8'h30, 32'd31);
        wr(8'h2c, 32'h41);
        wr(8'h1c, 32'h1);
        wr(8'h2c, 32'h42);
        rd("name", 8'h2c, 32'h41);
        wr(8'h18, 32'd1);
        wr(8'h1c, 32'h2);
        rd("members1", 8'h28, 32'h0);
        fwd(5'd7, 26'h0);
        $display("test vlan done");
        stop_test();
    end
endmodule
